// [inc/eeprom_pkg.sv]
// constants, opcodes and state type shared by the serial eeprom command logic
package eeprom_pkg;

    // opcode layout: upper nibble zero, bit 3 ignored, low three bits select
    localparam logic [3:0] OPC_UPPER      = 4'h0;
    localparam logic [2:0] OPC_SET_LATCH  = 3'h6;
    localparam logic [2:0] OPC_CLR_LATCH  = 3'h4;
    localparam logic [2:0] OPC_STATUS_RD  = 3'h5;
    localparam logic [2:0] OPC_STATUS_WR  = 3'h1;
    localparam logic [2:0] OPC_READ       = 3'h3;
    localparam logic [2:0] OPC_WRITE      = 3'h2;

    // status byte field positions
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_LATCH_BIT   = 1;
    localparam int ST_BP_LOW_BIT  = 2;
    localparam int ST_BP_HIGH_BIT = 3;
    localparam int ST_PPE_BIT     = 7;
    // status read value while a program cycle runs
    localparam logic [7:0] STATUS_BUSY_VAL = 8'hff;

    // block protect levels
    localparam logic [1:0] BP_NONE    = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF    = 2'h2;
    localparam logic [1:0] BP_ALL     = 2'h3;

    // reset values of the volatile model of the status cells
    localparam logic       PPE_RST   = 1'b0;
    localparam logic [1:0] BP_RST    = 2'h0;
    localparam logic       LATCH_RST = 1'b0;

    // array geometry
    localparam int          ARRAY_AW   = 15;
    localparam int          MEM_DEPTH  = 32768;
    localparam int          PAGE_AW    = 6;
    localparam int          PAGE_BYTES = 64;
    localparam logic [14:0] MASK_LARGE = 15'h7fff;
    localparam logic [14:0] MASK_SMALL = 15'h3fff;

    // load fifo: page offset plus data byte
    localparam int FIFO_W     = 14;
    localparam int FIFO_DEPTH = 8;

    // default length of the self-timed program cycle, in mclk cycles
    localparam int PROG_CYCLES_DEF = 5000;

    // command parser states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPC,
        ST_ADDR,
        ST_DATA_IN,
        ST_DATA_OUT,
        ST_STATUS_IN,
        ST_STATUS_OUT,
        ST_IGNORE
    } parse_state_t;

endpackage

// [hdl/spi_eeprom_rw_protect.sv]
// serial eeprom slave command logic with load fifo, page buffer and protection
`timescale 1ns/10ps

// small synchronous fifo, width and depth set by parameters
module load_fifo #(
    parameter int W     = 14,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] store [DEPTH];   // entry storage
    logic [AW:0]  wr_ptr_r;        // write pointer with wrap bit
    logic [AW:0]  rd_ptr_r;        // read pointer with wrap bit

    wire do_push = in_valid & in_ready;
    wire do_pop  = out_valid & out_ready;

    // full when pointers differ only in the wrap bit
    assign in_ready  = ~((wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                         (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign out_data  = store[rd_ptr_r[AW-1:0]];

    // storage write, no reset needed
    always_ff @(posedge mclk) begin
        if (do_push) begin
            store[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    // pointer update
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule // load_fifo

module spi_eeprom_rw_protect #(
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES_DEF
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // serial link from the master
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    output logic      so_o,
    output logic      so_oe,
    // protection pin and size strap
    input  wire logic wp_n,
    input  wire logic large_variant,
    // load fifo full indication
    output logic      load_stall
);
    // pin synchronisers: cs_n, sck, si, wp_n, large_variant
    logic [4:0] meta_r;            // first stage, read only by sync_r
    logic [4:0] sync_r;            // second stage
    logic       sck_d_r;           // delayed sck for edge detection
    logic       cs_d_r;            // delayed select for edge detection

    wire cs_s    = sync_r[4];
    wire sck_s   = sync_r[3];
    wire si_s    = sync_r[2];
    wire wp_s    = sync_r[1];
    wire large_s = sync_r[0];

    // parser state
    eeprom_pkg::parse_state_t state_r;
    logic [2:0]  bit_cnt_r;        // received bits of current byte
    logic [2:0]  out_cnt_r;        // sent bits of current byte
    logic [6:0]  in_sr_r;          // receive shift register
    logic [7:0]  out_sr_r;         // transmit shift register
    logic [14:0] addr_r;           // array address
    logic        hi_done_r;        // high address byte received
    logic        is_write_r;       // address phase belongs to a write
    logic        byte_seen_r;      // at least one whole data byte accepted
    logic        load_req_r;       // fetch array byte into out_sr next cycle
    logic        so_r;             // serial output
    logic        so_oe_r;          // serial output enable
    logic        stall_r;          // fifo full, registered

    // status cells and program engine
    logic        pin_protect_enable_bit_r;           // pin_protect_enable_bit
    logic [1:0]  bp_r;             // block_protect_high, block_protect_low
    logic        wel_r;            // write enable latch
    logic [7:0]  stat_new_r;       // captured status write byte
    logic        stat_seen_r;      // status byte captured this frame
    logic        stat_pend_r;      // status update rides the program cycle
    logic        arr_pend_r;       // array program waiting for fifo drain
    logic        prog_r;           // program cycle busy
    logic [31:0] prog_cnt_r;       // program cycle counter

    // array and page buffer
    logic [7:0]  mem [eeprom_pkg::MEM_DEPTH];
    logic [7:0]  pg_data [eeprom_pkg::PAGE_BYTES];
    logic [63:0] pg_valid_r;       // page slots loaded this cycle

    // fifo wires
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [13:0] fifo_out_data;

    // edges of the synchronised link
    wire sck_rise = sck_s & ~sck_d_r & ~cs_s;
    wire sck_fall = ~sck_s & sck_d_r & ~cs_s;
    wire cs_fall  = ~cs_s & cs_d_r;
    wire cs_rise  = cs_s & ~cs_d_r;

    // received byte including the bit on this edge, msb first
    wire [7:0] in_byte   = {in_sr_r, si_s};
    wire       byte_done = sck_rise & (bit_cnt_r == 3'h7);

    // opcode decode, bit 3 ignored
    wire opc_ok = (in_byte[7:4] == eeprom_pkg::OPC_UPPER);
    wire is_set = opc_ok & (in_byte[2:0] == eeprom_pkg::OPC_SET_LATCH);
    wire is_clr = opc_ok & (in_byte[2:0] == eeprom_pkg::OPC_CLR_LATCH);
    wire is_srd = opc_ok & (in_byte[2:0] == eeprom_pkg::OPC_STATUS_RD);
    wire is_swr = opc_ok & (in_byte[2:0] == eeprom_pkg::OPC_STATUS_WR);
    wire is_rd  = opc_ok & (in_byte[2:0] == eeprom_pkg::OPC_READ);
    wire is_wr  = opc_ok & (in_byte[2:0] == eeprom_pkg::OPC_WRITE);

    // address decode by variant
    wire [14:0] amask    = large_s ? eeprom_pkg::MASK_LARGE : eeprom_pkg::MASK_SMALL;
    wire [14:0] eff_addr = addr_r & amask;
    wire [1:0]  top2     = large_s ? eff_addr[14:13] : eff_addr[13:12];

    // block protection of the current address
    wire blk_prot = (bp_r == eeprom_pkg::BP_ALL) |
                    ((bp_r == eeprom_pkg::BP_HALF) & top2[1]) |
                    ((bp_r == eeprom_pkg::BP_QUARTER) & (top2 == 2'h3));

    // write permission
    wire hw_prot      = pin_protect_enable_bit_r & ~wp_s;
    wire status_wr_ok = wel_r & ~hw_prot;
    wire arr_wr_ok    = wel_r & ~blk_prot;

    // status byte as read
    wire [7:0] status_byte = prog_r ? eeprom_pkg::STATUS_BUSY_VAL :
                             {pin_protect_enable_bit_r, 3'h0, bp_r, wel_r, 1'b0};

    // fifo fill and drain
    wire        push_valid = (state_r == eeprom_pkg::ST_DATA_IN) & byte_done & arr_wr_ok;
    wire [13:0] push_data  = {addr_r[5:0], in_byte};
    wire        drain_rdy  = ~prog_r;
    wire        drain      = fifo_out_valid & drain_rdy;

    // program engine
    wire [31:0] prog_last  = 32'(PROG_CYCLES - 1);
    wire        prog_start = (arr_pend_r | stat_pend_r) & ~fifo_out_valid & ~prog_r;
    wire        prog_done  = prog_r & (prog_cnt_r == prog_last);
    wire [5:0]  pg_idx     = prog_cnt_r[5:0];
    wire        pg_wr      = prog_r & (prog_cnt_r < 32'(eeprom_pkg::PAGE_BYTES)) &
                             pg_valid_r[pg_idx];
    wire [14:0] pg_addr    = {eff_addr[14:6], pg_idx} & amask;

    wire out_state = (state_r == eeprom_pkg::ST_DATA_OUT) |
                     (state_r == eeprom_pkg::ST_STATUS_OUT);

    load_fifo #(
        .W     (eeprom_pkg::FIFO_W),
        .DEPTH (eeprom_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (drain_rdy),
        .out_data  (fifo_out_data)
    );

    // two-flop synchronisers and edge history
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r  <= 5'h1c;
            sync_r  <= 5'h1c;
            sck_d_r <= 1'b1;
            cs_d_r  <= 1'b1;
        end else begin
            meta_r  <= {cs_n, sck, si, wp_n, large_variant};
            sync_r  <= meta_r;
            sck_d_r <= sck_s;
            cs_d_r  <= cs_s;
        end
    end

    // command parser
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r     <= eeprom_pkg::ST_IDLE;
            bit_cnt_r   <= 3'h0;
            in_sr_r     <= 7'h0;
            addr_r      <= 15'h0;
            hi_done_r   <= 1'b0;
            is_write_r  <= 1'b0;
            byte_seen_r <= 1'b0;
        end else if (cs_fall) begin
            // each command opens with select falling
            state_r     <= eeprom_pkg::ST_OPC;
            bit_cnt_r   <= 3'h0;
            hi_done_r   <= 1'b0;
            byte_seen_r <= 1'b0;
        end else if (cs_rise) begin
            // back to standby until the next select
            state_r <= eeprom_pkg::ST_IDLE;
        end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            in_sr_r   <= in_byte[6:0];
            if (byte_done) begin
                unique case (state_r)
                    eeprom_pkg::ST_OPC: begin
                        is_write_r <= is_wr;
                        if (prog_r && !is_srd) begin
                            // busy: only status read is honoured
                            state_r <= eeprom_pkg::ST_IGNORE;
                        end else if (is_srd) begin
                            state_r <= eeprom_pkg::ST_STATUS_OUT;
                        end else if (is_rd || (is_wr && wel_r)) begin
                            state_r <= eeprom_pkg::ST_ADDR;
                        end else if (is_swr && wel_r) begin
                            state_r <= eeprom_pkg::ST_STATUS_IN;
                        end else begin
                            // latch commands, invalid opcodes, writes without latch
                            state_r <= eeprom_pkg::ST_IGNORE;
                        end
                    end
                    eeprom_pkg::ST_ADDR: begin
                        addr_r    <= {addr_r[6:0], in_byte};
                        hi_done_r <= 1'b1;
                        if (hi_done_r) begin
                            state_r <= is_write_r ? eeprom_pkg::ST_DATA_IN :
                                                    eeprom_pkg::ST_DATA_OUT;
                        end
                    end
                    eeprom_pkg::ST_DATA_IN: begin
                        // page write steps only the low six bits, wrapping in page
                        addr_r[5:0] <= addr_r[5:0] + 6'h1;
                        byte_seen_r <= byte_seen_r | arr_wr_ok;
                    end
                    default: begin
                        state_r <= state_r;
                    end
                endcase
            end
        end else if (sck_fall && state_r == eeprom_pkg::ST_DATA_OUT &&
                     out_cnt_r == 3'h7) begin
            // next byte of a continuous read, wrapping at the top
            addr_r <= eff_addr + 15'h1;
        end
    end

    // transmit path, shifts on sck falling
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            out_sr_r   <= 8'h0;
            out_cnt_r  <= 3'h0;
            load_req_r <= 1'b0;
            so_r       <= 1'b0;
        end else begin
            load_req_r <= 1'b0;
            if (cs_fall) begin
                out_cnt_r <= 3'h0;
            end else if (byte_done && state_r == eeprom_pkg::ST_OPC && is_srd) begin
                out_sr_r <= status_byte;
            end else if (byte_done && state_r == eeprom_pkg::ST_ADDR && hi_done_r &&
                         !is_write_r) begin
                load_req_r <= 1'b1;
            end else if (load_req_r) begin
                out_sr_r <= mem[eff_addr];
            end else if (sck_fall && out_state) begin
                // serial input ignored here, byte goes out msb first
                so_r      <= out_sr_r[7];
                out_sr_r  <= {out_sr_r[6:0], 1'b0};
                out_cnt_r <= out_cnt_r + 3'h1;
                if (out_cnt_r == 3'h7) begin
                    if (state_r == eeprom_pkg::ST_STATUS_OUT) begin
                        out_sr_r <= status_byte;
                    end else begin
                        load_req_r <= 1'b1;
                    end
                end
            end
        end
    end

    // output enable and stall flags
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            so_oe_r <= 1'b0;
            stall_r <= 1'b0;
        end else begin
            so_oe_r <= out_state & ~cs_s;
            stall_r <= ~fifo_in_ready;
        end
    end

    // status cells, latch and program cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_protect_enable_bit_r      <= eeprom_pkg::PPE_RST;
            bp_r        <= eeprom_pkg::BP_RST;
            wel_r       <= eeprom_pkg::LATCH_RST;
            stat_new_r  <= 8'h0;
            stat_seen_r <= 1'b0;
            stat_pend_r <= 1'b0;
            arr_pend_r  <= 1'b0;
            prog_r      <= 1'b0;
            prog_cnt_r  <= 32'h0;
        end else begin
            // latch commands, refused while busy
            if (byte_done && state_r == eeprom_pkg::ST_OPC && !prog_r) begin
                if (is_set) begin
                    wel_r <= 1'b1;
                end else if (is_clr) begin
                    wel_r <= 1'b0;
                end
            end
            if (cs_fall) begin
                stat_seen_r <= 1'b0;
            end
            // capture a whole status byte only when writable
            if (byte_done && state_r == eeprom_pkg::ST_STATUS_IN && status_wr_ok) begin
                stat_new_r  <= in_byte;
                stat_seen_r <= 1'b1;
            end
            // commit on select rising after whole bytes only
            if (cs_rise && bit_cnt_r == 3'h0) begin
                if (state_r == eeprom_pkg::ST_DATA_IN && byte_seen_r) begin
                    arr_pend_r <= 1'b1;
                end
                if (state_r == eeprom_pkg::ST_STATUS_IN && stat_seen_r && status_wr_ok) begin
                    stat_pend_r <= 1'b1;
                end
            end
            if (prog_start) begin
                prog_r     <= 1'b1;
                prog_cnt_r <= 32'h0;
            end else if (prog_done) begin
                // self-timed cycle over: busy and latch drop together
                prog_r      <= 1'b0;
                wel_r       <= 1'b0;
                arr_pend_r  <= 1'b0;
                stat_pend_r <= 1'b0;
                if (stat_pend_r) begin
                    pin_protect_enable_bit_r <= stat_new_r[eeprom_pkg::ST_PPE_BIT];
                    bp_r   <= {stat_new_r[eeprom_pkg::ST_BP_HIGH_BIT],
                               stat_new_r[eeprom_pkg::ST_BP_LOW_BIT]};
                end
            end else if (prog_r) begin
                prog_cnt_r <= prog_cnt_r + 32'h1;
            end
        end
    end

    // page buffer load from the fifo, later bytes replace earlier ones
    always_ff @(posedge mclk) begin
        if (drain) begin
            pg_data[fifo_out_data[13:8]] <= fifo_out_data[7:0];
        end
    end

    // page slot valid flags
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pg_valid_r <= 64'h0;
        end else if (prog_done) begin
            pg_valid_r <= 64'h0;
        end else if (drain) begin
            pg_valid_r[fifo_out_data[13:8]] <= 1'b1;
        end
    end

    // array write, one page slot per cycle at the start of the program cycle
    always_ff @(posedge mclk) begin
        if (pg_wr && !stat_pend_r) begin
            mem[pg_addr] <= pg_data[pg_idx];
        end
    end

    assign so_o       = so_r;
    assign so_oe      = so_oe_r;
    assign load_stall = stall_r;
endmodule // spi_eeprom_rw_protect

// [verif/spi_eeprom_monitor.sv]
// port checker for the serial eeprom command logic
`timescale 1ns/10ps
module spi_eeprom_monitor #(
    parameter int PROG_CYCLES = 5000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // serial link and straps
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_o,
    input wire logic so_oe,
    input wire logic wp_n,
    input wire logic large_variant,
    input wire logic load_stall
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_oe_idle; cs_n [*6] |-> !so_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("so driven while deselected");
    property p_oe_drop; $rose(cs_n) |-> ##[1:8] !so_oe; endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("so not released");
    property p_oe_open; $fell(cs_n) |-> !so_oe [*8]; endproperty
    a_oe_open: assert property (p_oe_open) else $error("so driven during opcode");
    property p_oe_rise; $rose(so_oe) |-> !cs_n && $past(!cs_n, 8); endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("so enabled outside frame");
    property p_oe_fall; $fell(so_oe) |-> $past(cs_n, 2); endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("so dropped mid frame");
    property p_so_edge; so_oe && $past(so_oe) && $changed(so_o) |-> !sck; endproperty
    a_so_edge: assert property (p_so_edge) else $error("so changed with sck high");
    property p_so_hold; so_oe && $past(so_oe) && sck && $past(sck, 2) |-> $stable(so_o); endproperty
    a_so_hold: assert property (p_so_hold) else $error("so unstable while sampled");
    property p_no_stall; !load_stall; endproperty
    a_no_stall: assert property (p_no_stall) else $error("load fifo overflow");
    c_read: cover property ($rose(so_oe));
    c_done: cover property ($fell(so_oe));
    c_frame: cover property ($rose(cs_n));
endmodule // spi_eeprom_monitor
bind spi_eeprom_rw_protect spi_eeprom_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_spi_eeprom_monitor (
    .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o),
    .so_oe(so_oe), .wp_n(wp_n), .large_variant(large_variant), .load_stall(load_stall));

// [verif/spi_master_model.sv]
// serial master model driving select, clock and data toward the eeprom
`timescale 1ns/10ps
module spi_master_model (
    // clock
    input  wire logic mclk,
    // serial link
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so_o,
    input  wire logic so_oe
);
    logic so_line; // data line, pulled high when released
    assign so_line = so_oe ? so_o : 1'b1;
    // idle: deselected, clock low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b1;
    end
    // half of the 160 ns serial clock period
    task automatic half();
        repeat (10) @(posedge mclk);
    endtask
    // one byte each way, msb first, answer taken at sck rising
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            half();
            sck <= 1'b1;
            rx[i] = so_line;
            half();
            sck <= 1'b0;
        end
    endtask
    // select opens a frame, deselect in the low time after the last bit
    task automatic sel();
        cs_n <= 1'b0;
        half();
    endtask
    task automatic desel();
        repeat (2) @(posedge mclk);
        cs_n <= 1'b1;
        si <= ~si;
        half();
    endtask
endmodule // spi_master_model

// [verif/spi_eeprom_rw_protect_tb_top.sv]
// self-checking bench for the serial eeprom command logic
`timescale 1ns/10ps
module spi_eeprom_rw_protect_tb_top;
    logic mclk = 1'b0, reset_n = 1'b0, wp_n = 1'b1, large_variant = 1'b1;
    logic cs_n, sck, si, so_o, so_oe, load_stall; // link wires
    logic [7:0] rx[$]; // bytes answered in the last frame
    int failures = 0, n_checks = 0;
    always #4 mclk = ~mclk;
    spi_eeprom_rw_protect #(.PROG_CYCLES(400)) i_spi_eeprom_rw_protect (.mclk(mclk),
        .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o), .so_oe(so_oe),
        .wp_n(wp_n), .large_variant(large_variant), .load_stall(load_stall));
    spi_master_model i_spi_master_model (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si),
        .so_o(so_o), .so_oe(so_oe));
    // verdict and end of run
    task automatic finish_test();
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // compare one answered byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one whole frame of bytes, answers kept in rx
    task automatic frame(input logic [7:0] tx[$]);
        logic [7:0] b;
        rx = {};
        i_spi_master_model.sel();
        foreach (tx[i]) begin
            i_spi_master_model.xb(tx[i], b);
            rx.push_back(b);
        end
        i_spi_master_model.desel();
    endtask
    // poll status until the program cycle ends, bounded
    task automatic wait_ready();
        for (int k = 0; k < 40; k++) begin
            frame({8'h05, 8'h00});
            if (rx[1][0] === 1'b0) return;
        end
        failures++;
        $display("[ERR] %0t busy never cleared", $time);
        finish_test();
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        frame({8'h05, 8'h00});
        chk(rx[1], 8'h00);
        frame({8'h0e});
        frame({8'h05, 8'h00});
        chk(rx[1], 8'h02);
        frame({8'h02, 8'h00, 8'h00, 8'ha5});
        frame({8'h05, 8'h00});
        chk(rx[1], 8'hff);
        wait_ready();
        chk(rx[1], 8'h00);
        frame({8'h02, 8'h00, 8'h00, 8'h5a});
        wait_ready();
        frame({8'h03, 8'h00, 8'h00, 8'h00});
        chk(rx[3], 8'ha5);
        frame({8'h06});
        frame({8'h02, 8'h7f, 8'hfe, 8'h44, 8'h55, 8'h66});
        wait_ready();
        frame({8'h03, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00});
        chk(rx[3], 8'h44);
        chk(rx[4], 8'h55);
        chk(rx[5], 8'ha5);
        frame({8'h0b, 8'h7f, 8'hc0, 8'h00});
        chk(rx[3], 8'h66);
        frame({8'h06});
        frame({8'h01, 8'h84});
        wait_ready();
        chk(rx[1], 8'h84);
        wp_n <= 1'b0;
        frame({8'h06});
        frame({8'h02, 8'h00, 8'h00, 8'h77, 8'h7f, 8'hfe, 8'h99});
        wait_ready();
        frame({8'h03, 8'h00, 8'h00, 8'h00});
        chk(rx[3], 8'h77);
        frame({8'h03, 8'h7f, 8'hfe, 8'h00});
        chk(rx[3], 8'h44);
        frame({8'h06});
        frame({8'h01, 8'h00});
        wait_ready();
        frame({8'h0c});
        frame({8'h05, 8'h00});
        chk(rx[1], 8'h84);
        wp_n <= 1'b1;
        frame({8'h06});
        frame({8'h01, 8'h00});
        wait_ready();
        chk(rx[1], 8'h00);
        finish_test();
    end
endmodule // spi_eeprom_rw_protect_tb_top
